// ===== msq_defines.svh
// Constants of the magnetometer command sequencer
// Assumes a 25 MHz system clock and a 1060 Hz station pulse
`ifndef MSQ_DEFINES_SVH
`define MSQ_DEFINES_SVH
// Clock and timing
`define MSQ_CLK_HZ        25000000
`define MSQ_PULSE_HZ      1060
`define MSQ_STEP_TIME_S   10
`define MSQ_STEP_CYCLES   (`MSQ_STEP_TIME_S * `MSQ_CLK_HZ)
`define MSQ_CAL_HOURS     18
`define MSQ_CAL_PULSES    (`MSQ_CAL_HOURS * 3600 * `MSQ_PULSE_HZ)
`define MSQ_RASTER_STEPS  5'h10
// Harmonic toggles per group of station pulses (11.925 kHz)
`define MSQ_REF_TOGGLES   20'h0_00B4
`define MSQ_REF_PULSES    3'h7
// Command numbers
`define MSQ_CMD_RANGE     4'h1
`define MSQ_CMD_OFS_APPLY 4'h2
`define MSQ_CMD_OFS_ADDR  4'h3
`define MSQ_CMD_INHIBIT   4'h4
`define MSQ_CMD_CAL       4'h5
`define MSQ_CMD_BYPASS    4'h6
`define MSQ_CMD_SURVEY    4'h7
`define MSQ_CMD_THERMAL   4'h8
`define MSQ_SURVEY_MIN    3'h4
// Register byte offsets
`define MSQ_REG_STATUS    12'h000
`define MSQ_REG_POSITION  12'h004
`define MSQ_REG_IRQ_STAT  12'h008
`define MSQ_REG_IRQ_MASK  12'h00C
`define MSQ_REG_DATA      12'h010
// Interrupt bits
`define MSQ_IRQ_CAL_DONE  0
`define MSQ_IRQ_SRV_DONE  1
`define MSQ_IRQ_CMD_REJ   2
`define MSQ_IRQ_OVERRUN   3
`define MSQ_IRQ_W         4
// Reset values
`define MSQ_RST_RANGE     2'h1
`define MSQ_RST_INHIBIT   1'h1
`endif

// ===== msq_pkg.sv
// Types of the magnetometer command sequencer
// Assumes nothing beyond the tool's SystemVerilog support
`default_nettype none
package msq_pkg;
  // Flip/cal sequence, Gray coded from MSQ_F_IDLE to MSQ_F_CALB; CALB back to IDLE changes all three bits
  typedef enum logic [2:0] {
    MSQ_F_IDLE  = 3'h0,
    MSQ_F_CALA  = 3'h1,
    MSQ_F_FLX   = 3'h3,
    MSQ_F_FLY   = 3'h2,
    MSQ_F_FLZ   = 3'h6,
    MSQ_F_CALB  = 3'h7
  } msq_fstate_t;
  // Thermal control source
  typedef enum logic [1:0] {
    MSQ_T_XBOOM = 2'h0,
    MSQ_T_YBOOM = 2'h1,
    MSQ_T_OFF   = 2'h2
  } msq_therm_t;
endpackage
`default_nettype wire

// ===== msq_refgen.sv
// Reference square waves locked to the station clock pulse
// Assumes clk_pulse_in is a synchronous one-cycle-or-longer level
`include "msq_defines.svh"
`default_nettype none
module msq_refgen (
  input  wire logic sys_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic clk_pulse_in,
  output logic      fund_out,
  output logic      harm_out
);
  logic        pulse_d;
  logic [15:0] per_cnt;
  logic [15:0] period;
  logic [2:0]  grp;
  logic [19:0] acc;
  logic        rise;
  logic [19:0] modulus;
  assign rise = clk_pulse_in & ~pulse_d;
  assign modulus = {1'b0, period, 3'h0};
  // Measure the pulse period in system clocks
  always_ff @(posedge sys_clk_in) begin
    pulse_d <= sys_rst_in ? 1'b0 : clk_pulse_in;
    if (sys_rst_in || rise) per_cnt <= 16'h0_000;
    else per_cnt <= per_cnt + 16'h0_001;
    if (sys_rst_in) period <= 16'h5_C21;
    else if (rise) period <= per_cnt + 16'h0_001;
  end
  // Phase accumulator, re-aligned every eight pulses to stop drift
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      grp <= 3'h0; acc <= 20'h0_0000; harm_out <= 1'b0; fund_out <= 1'b0;
    end else if (rise && grp == `MSQ_REF_PULSES) begin
      grp <= 3'h0; acc <= 20'h0_0000; harm_out <= 1'b0; fund_out <= 1'b0;
    end else begin
      if (rise) grp <= grp + 3'h1;
      if (acc + `MSQ_REF_TOGGLES >= modulus) begin
        acc <= acc + `MSQ_REF_TOGGLES - modulus;
        harm_out <= ~harm_out;
        if (harm_out) fund_out <= ~fund_out;
      end else acc <= acc + `MSQ_REF_TOGGLES;
    end
  end
endmodule
`default_nettype wire

// ===== msq_flipseq.sv
// Flip/calibration sequencer: raster, X, Y, Z flips, raster
// Assumes start_in is a one-cycle pulse, ignored while busy
`include "msq_defines.svh"
`default_nettype none
module msq_flipseq #(
  parameter int unsigned STEP_CYCLES = `MSQ_STEP_CYCLES
) (
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       start_in,
  output logic            busy_out,
  output logic            raster_out,
  output logic            done_out,
  output logic [2:0]      motor_out,
  output logic [2:0]      flipped_out
);
  msq_pkg::msq_fstate_t state;
  logic [31:0] step_cnt;
  logic [4:0]  ras_cnt;
  logic        tick;
  assign tick = step_cnt == 32'(STEP_CYCLES - 1);
  assign busy_out = state != msq_pkg::MSQ_F_IDLE;
  assign raster_out = state == msq_pkg::MSQ_F_CALA || state == msq_pkg::MSQ_F_CALB;
  // One motor powered at a time
  assign motor_out = {state == msq_pkg::MSQ_F_FLZ, state == msq_pkg::MSQ_F_FLY,
                      state == msq_pkg::MSQ_F_FLX};
  // Step timer, restarted on each state change
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !busy_out || tick) step_cnt <= 32'h0000_0000;
    else step_cnt <= step_cnt + 32'h0000_0001;
  end
  // Sequence; a jammed motor only costs its own time slot
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state <= msq_pkg::MSQ_F_IDLE; ras_cnt <= 5'h00; done_out <= 1'b0;
      flipped_out <= 3'h0;
    end else begin
      done_out <= 1'b0;
      case (state)
        msq_pkg::MSQ_F_IDLE: if (start_in) state <= msq_pkg::MSQ_F_CALA;
        msq_pkg::MSQ_F_CALA, msq_pkg::MSQ_F_CALB: if (tick) begin
          if (ras_cnt == `MSQ_RASTER_STEPS - 5'h01) begin
            ras_cnt <= 5'h00;
            done_out <= state == msq_pkg::MSQ_F_CALB;
            state <= state == msq_pkg::MSQ_F_CALA ? msq_pkg::MSQ_F_FLX
                                                 : msq_pkg::MSQ_F_IDLE;
          end else ras_cnt <= ras_cnt + 5'h01;
        end
        msq_pkg::MSQ_F_FLX: if (tick) begin
          flipped_out[0] <= ~flipped_out[0]; state <= msq_pkg::MSQ_F_FLY;
        end
        msq_pkg::MSQ_F_FLY: if (tick) begin
          flipped_out[1] <= ~flipped_out[1]; state <= msq_pkg::MSQ_F_FLZ;
        end
        msq_pkg::MSQ_F_FLZ: if (tick) begin
          flipped_out[2] <= ~flipped_out[2]; state <= msq_pkg::MSQ_F_CALB;
        end
        default: state <= msq_pkg::MSQ_F_IDLE;
      endcase
    end
  end
  property p_one_motor;
    @(posedge sys_clk_in) disable iff (sys_rst_in) $onehot0(motor_out);
  endproperty
  a_one_motor: assert property (p_one_motor) else $error("two flip motors on");
endmodule
`default_nettype wire

// ===== msq_top.sv
// Magnetometer command decode, sequencing, status and APB registers
// Assumes commands arrive as one-cycle strobes from the station decoder
// How it works
// - Command 1 selects one of three ranges, 50, 100 or 200 units.
// - Station timer starts flip/cal every 18 hours unless inhibited or the sequencer is already busy.
// - Command 4 toggles the cal inhibit; it must release before command 5.
// - Command 5 starts flip/cal whenever the sequencer is idle once the inhibit is released.
// - Command 7 starts the site survey; only after four flip/cal cycles.
// - Command 6 bypasses most of the digital filter.
// - Command 8 picks X boom, Y boom or off as thermal source.
// - Command 3 picks offset channels; command 2 applies the offset.
// - Each sensor's flip position is a 2-bit status word.
// - Each sensor's gimbal position is a 1-bit status word.
// - Reference waves at 5.9625 and 11.925 kHz locked to 1060 Hz.
// - Digitized data is held until the data subsystem asks for it.
// - Heater power and temperature control status are reported.
// - The sequencer powers the flip motors one at a time.
`include "msq_defines.svh"
`default_nettype none
module msq_top #(
  parameter int unsigned STEP_CYCLES = `MSQ_STEP_CYCLES,
  parameter int unsigned CAL_PULSES  = `MSQ_CAL_PULSES
) (
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             irq_out,
  input  wire logic        cmd_valid_in,
  input  wire logic [3:0]  cmd_num_in,
  input  wire logic [7:0]  cmd_arg_in,
  input  wire logic        clk_pulse_in,
  input  wire logic        sample_valid_in,
  input  wire logic [31:0] sample_in,
  input  wire logic        data_req_in,
  output logic      [31:0] data_out,
  output logic             data_valid_out,
  input  wire logic        heater_on_in,
  input  wire logic        temp_ctrl_in,
  output logic             heater_status_out,
  output logic             temp_ctrl_status_out,
  output logic      [1:0]  range_out,
  output logic      [2:0]  offset_sel_out,
  output logic      [7:0]  offset_pct_out,
  output logic      [2:0]  offset_apply_out,
  output logic             cal_inhibit_out,
  output logic             filter_bypass_out,
  output logic      [1:0]  thermal_src_out,
  output logic      [2:0]  motor_out,
  output logic             raster_out,
  output logic             survey_out,
  output logic      [5:0]  flip_pos_out,
  output logic      [2:0]  gimbal_post_out,
  output logic             ref_fund_out,
  output logic             ref_harm_out
);
  // Decoded command strobes, one per defined command
  logic [8:1] cmd;
  logic       cmd_bad;
  logic       cal_start;
  logic       timer_due;
  logic       seq_busy;
  logic       seq_raster;
  logic       seq_done;
  logic [2:0] seq_motor;
  logic [2:0] seq_flipped;
  logic       fund;
  logic       harm;
  logic [2:0] cal_count;
  logic [1:0] srv_axis;
  logic       srv_wait;
  logic       srv_req;
  logic       srv_done;
  logic [31:0] held;
  logic       held_full;
  logic [`MSQ_IRQ_W-1:0] irq_stat;
  logic [`MSQ_IRQ_W-1:0] irq_mask;
  logic [`MSQ_IRQ_W-1:0] irq_set;
  logic       pulse_d;
  logic [31:0] int_cnt;
  logic       apb_rd;
  logic       apb_wr;
  logic       known;
  msq_pkg::msq_therm_t therm;

  // Register address decode, used only by the error path
  function automatic logic reg_known(input logic [11:0] a);
    reg_known = a == `MSQ_REG_STATUS || a == `MSQ_REG_POSITION ||
                a == `MSQ_REG_IRQ_STAT || a == `MSQ_REG_IRQ_MASK ||
                a == `MSQ_REG_DATA;
  endfunction

  // Flip position word: 2'h0 at 0 deg, 2'h1 at 90, 2'h2 at 180
  function automatic logic [1:0] pos_word(input logic flipped, input logic srv);
    pos_word = srv ? 2'h1 : (flipped ? 2'h2 : 2'h0);
  endfunction

  // Command strobes; anything outside 1..8 is flagged and dropped
  genvar gi;
  generate
    for (gi = 1; gi <= 8; gi++) begin : g_cmd
      assign cmd[gi] = cmd_valid_in && cmd_num_in == 4'(gi);
    end
  endgenerate
  assign cmd_bad = cmd_valid_in && cmd_num_in != 4'h0 && (cmd_num_in > `MSQ_CMD_THERMAL)
                 || cmd_valid_in && cmd_num_in == 4'h0;

  msq_flipseq #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_seq (
    .sys_clk_in  (sys_clk_in),
    .sys_rst_in  (sys_rst_in),
    .start_in    (cal_start),
    .busy_out    (seq_busy),
    .raster_out  (seq_raster),
    .done_out    (seq_done),
    .motor_out   (seq_motor),
    .flipped_out (seq_flipped)
  );

  msq_refgen u_ref (
    .sys_clk_in   (sys_clk_in),
    .sys_rst_in   (sys_rst_in),
    .clk_pulse_in (clk_pulse_in),
    .fund_out     (fund),
    .harm_out     (harm)
  );

  // Interval timer counts station pulses; it restarts after each tick
  always_ff @(posedge sys_clk_in) begin
    pulse_d <= sys_rst_in ? 1'b0 : clk_pulse_in;
    if (sys_rst_in || timer_due) int_cnt <= 32'h0000_0000;
    else if (clk_pulse_in && !pulse_d) int_cnt <= int_cnt + 32'h0000_0001;
  end
  assign timer_due = int_cnt == 32'(CAL_PULSES);

  // Every start source is gated by the inhibit
  assign cal_start = !cal_inhibit_out && !seq_busy &&
                     (cmd[5] || timer_due || srv_req);

  // Mode settings driven by commands
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      range_out <= `MSQ_RST_RANGE;
      cal_inhibit_out <= `MSQ_RST_INHIBIT;
      filter_bypass_out <= 1'b0;
      therm <= msq_pkg::MSQ_T_OFF;
    end else begin
      if (cmd[1] && cmd_arg_in[1:0] != 2'h0) range_out <= cmd_arg_in[1:0];
      if (cmd[4]) cal_inhibit_out <= ~cal_inhibit_out;
      if (cmd[6]) filter_bypass_out <= cmd_arg_in[0];
      if (cmd[8] && cmd_arg_in[1:0] != 2'h3) begin
        therm <= msq_pkg::msq_therm_t'(cmd_arg_in[1:0]);
      end
    end
  end

  // Offset address and percentage; apply drives only chosen channels
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      offset_sel_out <= 3'h0; offset_pct_out <= 8'h00; offset_apply_out <= 3'h0;
    end else begin
      if (cmd[3]) offset_sel_out <= cmd_arg_in[2:0];
      if (cmd[2]) begin
        offset_pct_out <= cmd_arg_in;
        offset_apply_out <= offset_sel_out;
      end
    end
  end

  // Cycle count toward the survey, saturating at the minimum
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) cal_count <= 3'h0;
    else if (seq_done && cal_count != `MSQ_SURVEY_MIN) cal_count <= cal_count + 3'h1;
  end

  // Site survey: one flip/cal per axis, then that sensor is gimballed
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      survey_out <= 1'b0; srv_axis <= 2'h0; srv_wait <= 1'b0; srv_req <= 1'b0;
      srv_done <= 1'b0; gimbal_post_out <= 3'h0;
    end else begin
      srv_done <= 1'b0;
      if (!survey_out) begin
        if (cmd[7] && cal_count == `MSQ_SURVEY_MIN && !seq_busy) begin
          survey_out <= 1'b1; srv_req <= 1'b1; srv_axis <= 2'h0;
        end
      end else if (srv_req) begin
        if (cal_start) begin
          srv_req <= 1'b0; srv_wait <= 1'b1;
        end
      end else if (srv_wait && seq_done) begin
        srv_wait <= 1'b0;
        gimbal_post_out[srv_axis] <= 1'b1;
        if (srv_axis == 2'h2) begin
          survey_out <= 1'b0; srv_done <= 1'b1;
        end else begin
          srv_axis <= srv_axis + 2'h1; srv_req <= 1'b1;
        end
      end
    end
  end

  // Registered status outputs and motor drive
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      motor_out <= 3'h0; raster_out <= 1'b0; flip_pos_out <= 6'h00;
      ref_fund_out <= 1'b0; ref_harm_out <= 1'b0; thermal_src_out <= 2'h2;
      heater_status_out <= 1'b0; temp_ctrl_status_out <= 1'b0;
    end else begin
      motor_out <= seq_motor;
      raster_out <= seq_raster;
      for (int i = 0; i < 3; i++) begin
        flip_pos_out[2*i +: 2] <= pos_word(seq_flipped[i],
                                           survey_out && srv_wait && 2'(i) == srv_axis);
      end
      ref_fund_out <= fund;
      ref_harm_out <= harm;
      thermal_src_out <= therm;
      heater_status_out <= heater_on_in;
      temp_ctrl_status_out <= temp_ctrl_in;
    end
  end

  // Sample holding: a new sample over an unread one counts as overrun
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      held <= 32'h0000_0000; held_full <= 1'b0;
      data_out <= 32'h0000_0000; data_valid_out <= 1'b0;
    end else begin
      data_valid_out <= data_req_in && held_full;
      if (data_req_in && held_full) data_out <= held;
      if (sample_valid_in) begin
        held <= sample_in; held_full <= 1'b1;
      end else if (data_req_in) held_full <= 1'b0;
    end
  end

  // Event sources for the sticky status
  assign irq_set[`MSQ_IRQ_CAL_DONE] = seq_done;
  assign irq_set[`MSQ_IRQ_SRV_DONE] = srv_done;
  assign irq_set[`MSQ_IRQ_CMD_REJ]  = cmd_bad || (cmd[5] && cal_inhibit_out) ||
                                      (cmd[7] && cal_count != `MSQ_SURVEY_MIN);
  assign irq_set[`MSQ_IRQ_OVERRUN]  = sample_valid_in && held_full && !data_req_in;

  // APB access phase, before the slave's one-cycle answer
  assign apb_rd = psel_in && penable_in && !pready_out && !pwrite_in;
  assign apb_wr = psel_in && penable_in && !pready_out && pwrite_in;
  assign known  = reg_known(paddr_in);

  // Sticky status: read clears, but a same-cycle event still lands
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) irq_stat <= '0;
    else if (apb_rd && paddr_in == `MSQ_REG_IRQ_STAT) irq_stat <= irq_set;
    else irq_stat <= irq_stat | irq_set;
  end

  // Mask register and the level interrupt
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) irq_mask <= '0;
    else if (apb_wr && paddr_in == `MSQ_REG_IRQ_MASK) irq_mask <= pwdata_in[`MSQ_IRQ_W-1:0];
    irq_out <= sys_rst_in ? 1'b0 : |(irq_stat & irq_mask);
  end

  // APB answer one cycle into the access phase; unmapped gives an error
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0; pslverr_out <= 1'b0; prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
      pslverr_out <= psel_in && penable_in && !pready_out && !known;
      prdata_out <= 32'h0000_0000;
      if (apb_rd) begin
        case (paddr_in)
          `MSQ_REG_STATUS: prdata_out <= {19'h0_0000, cal_count, survey_out, seq_busy,
                                          therm, filter_bypass_out, cal_inhibit_out,
                                          heater_on_in, temp_ctrl_in, range_out};
          `MSQ_REG_POSITION: prdata_out <= {23'h00_0000, gimbal_post_out, flip_pos_out};
          `MSQ_REG_IRQ_STAT: prdata_out <= {28'h000_0000, irq_stat};
          `MSQ_REG_IRQ_MASK: prdata_out <= {28'h000_0000, irq_mask};
          `MSQ_REG_DATA: prdata_out <= held;
          default: prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  property p_range;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      cmd[1] && cmd_arg_in[1:0] != 2'h0 |=> range_out == $past(cmd_arg_in[1:0]);
  endproperty
  a_range: assert property (p_range) else $error("range not taken");

  property p_timer_gate;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      cal_inhibit_out |=> !$rose(seq_busy);
  endproperty
  a_timer_gate: assert property (p_timer_gate) else $error("start while inhibited");

  property p_toggle;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      cmd[4] |=> cal_inhibit_out != $past(cal_inhibit_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("inhibit did not toggle");

  property p_cal_cmd;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      cmd[5] && !cal_inhibit_out && !seq_busy |=> seq_busy ##1 raster_out;
  endproperty
  a_cal_cmd: assert property (p_cal_cmd) else $error("cal not started");

  property p_survey_gate;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      $rose(survey_out) |-> $past(cal_count) == `MSQ_SURVEY_MIN;
  endproperty
  a_survey_gate: assert property (p_survey_gate) else $error("early survey");

  property p_bypass;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      cmd[6] |=> filter_bypass_out == $past(cmd_arg_in[0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not set");

  property p_offset;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      cmd[2] |=> offset_apply_out == $past(offset_sel_out);
  endproperty
  a_offset: assert property (p_offset) else $error("offset on wrong channels");

  property p_hold;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      data_req_in && held_full |=> data_valid_out && data_out == $past(held);
  endproperty
  a_hold: assert property (p_hold) else $error("held data not delivered");

  property p_bad_cmd;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      cmd_bad |-> cmd == 8'h00;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("unknown command decoded");

  property p_motor;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      $onehot0(motor_out);
  endproperty
  a_motor: assert property (p_motor) else $error("motors overlap");
endmodule
`default_nettype wire

// ===== msq_station_model.sv
// Model of the central station pulse source and the data subsystem
// Assumes the bench clock; station pulse scaled to one per 64 cycles
`default_nettype none
module msq_station_model (
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  output logic             clk_pulse_out,
  output logic             sample_valid_out,
  output logic      [31:0] sample_out,
  output logic             data_req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0]  tick;
  logic [31:0] seq;
  // Pulse, then a sample, then a request for it nine cycles later
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tick             <= 6'h00;
      seq              <= 32'h0000_0000;
      clk_pulse_out    <= 1'b0;
      sample_valid_out <= 1'b0;
      sample_out       <= 32'h0000_0000;
      data_req_out     <= 1'b0;
    end else begin
      tick             <= tick + 6'h01;
      clk_pulse_out    <= (tick == 6'h00);
      sample_valid_out <= (tick == 6'h0F);
      data_req_out     <= (tick == 6'h18);
      // Lines flip between samples so a stale value is never read
      if (tick == 6'h0F) begin
        seq        <= seq + 32'h1111_0001;
        sample_out <= seq + 32'h1111_0001;
      end else begin
        sample_out <= ~sample_out;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test_magnetometer_command_sequencing.sv
// Bench for the magnetometer command sequencer
// Assumes msq_top with shortened step and calibration counts
`default_nettype none
module test_magnetometer_command_sequencing;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, cvalid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, data, smp, exp_data, r;
  logic [3:0] cnum = 4'h0;
  logic [7:0] carg = 8'h00, pct;
  logic pready, pslverr, irq, pulse, svalid, dreq, dvalid, hstat, tstat, inh, byp;
  logic raster, survey, fund, harm, e, hq = 1'b0, fq = 1'b0, heat = 1'b1, tctl = 1'b0;
  logic [1:0] range, therm;
  logic [2:0] osel, oapp, motor, gimbal;
  logic [5:0] flip;
  int err_count = 0, samples_checked = 0;
  int nh = 0, nf = 0, h0 = 0, f0 = 0;
  msq_top #(.STEP_CYCLES(4), .CAL_PULSES(3)) msq_top_i (.sys_clk_in(clk), .sys_rst_in(rst),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
    .cmd_valid_in(cvalid), .cmd_num_in(cnum), .cmd_arg_in(carg), .clk_pulse_in(pulse),
    .sample_valid_in(svalid), .sample_in(smp), .data_req_in(dreq), .data_out(data),
    .data_valid_out(dvalid), .heater_on_in(heat), .temp_ctrl_in(tctl),
    .heater_status_out(hstat), .temp_ctrl_status_out(tstat), .range_out(range),
    .offset_sel_out(osel), .offset_pct_out(pct), .offset_apply_out(oapp),
    .cal_inhibit_out(inh), .filter_bypass_out(byp), .thermal_src_out(therm),
    .motor_out(motor), .raster_out(raster), .survey_out(survey), .flip_pos_out(flip),
    .gimbal_post_out(gimbal), .ref_fund_out(fund), .ref_harm_out(harm));
  msq_station_model msq_station_model_i (.sys_clk_in(clk), .sys_rst_in(rst),
    .clk_pulse_out(pulse), .sample_valid_out(svalid), .sample_out(smp), .data_req_out(dreq));
  always #20 clk = ~clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
    chk(e, experr);
  endtask
  // One command strobe, then one edge for the settings to land
  task cmd(input logic [3:0] n, input logic [7:0] a);
    @(posedge clk);
    cvalid <= 1'b1; cnum <= n; carg <= a;
    @(posedge clk);
    cvalid <= 1'b0;
    @(posedge clk);
  endtask
  task print_verdict;
    $display("Checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Held data must come out unchanged; motors never powered together
  always @(posedge clk) begin
    if (svalid) exp_data <= smp;
    if (dvalid) chk(data, exp_data);
    if (!rst && motor != 3'h0) chk({31'h0, $onehot(motor)}, 32'h1);
    // Reference wave changes, counted for the frequency check
    hq <= harm;
    fq <= fund;
    if (harm !== hq) nh <= nh + 1;
    if (fund !== fq) nf <= nf + 1;
  end
  initial begin
    #800000;
    err_count++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(range, 2'h1);
    chk(inh, 1'b1);
    chk(therm, 2'h2);
    chk(hstat, 1'b0);
    rd(12'h0FC, 32'h0000_0000, 1'b1);
    chk({hstat, tstat}, 2'h2);
    tctl <= 1'b1;
    cmd(4'h1, 8'h03);
    chk(range, 2'h3);
    cmd(4'h1, 8'h02);
    chk(range, 2'h2);
    cmd(4'h8, 8'h01);
    cmd(4'h8, 8'h03);
    chk(therm, 2'h1);
    cmd(4'h6, 8'h01);
    chk(byp, 1'b1);
    cmd(4'h3, 8'h05);
    cmd(4'h2, 8'h20);
    chk({oapp, osel, pct}, 14'h2D20);
    cmd(4'h9, 8'h01);
    chk(range, 2'h2);
    cmd(4'h5, 8'h00);
    @(posedge clk);
    chk({raster, motor}, 4'h0);
    cmd(4'h7, 8'h00);
    chk(survey, 1'b0);
    rd(12'h000, 32'h0000_007E, 1'b0);
    chk({hstat, tstat}, 2'h3);
    apb(1'b1, 12'h00C, 32'h0000_0001);
    cmd(4'h4, 8'h00);
    chk(inh, 1'b0);
    cmd(4'h5, 8'h00);
    @(posedge clk);
    chk(raster, 1'b1);
    repeat (400) if (irq !== 1'b1) @(posedge clk);
    chk(irq, 1'b1);
    chk(flip, 6'h2A);
    chk(gimbal, 3'h0);
    rd(12'h008, 32'h0000_0005, 1'b0);
    rd(12'h008, 32'h0000_0000, 1'b0);
    repeat (250) if (raster !== 1'b1) @(posedge clk);
    chk(raster, 1'b1);
    // Timer cals bring the count to four; waves are steady by now
    repeat (1100) @(posedge clk);
    h0 = nh;
    f0 = nf;
    // Eight station pulses span 512 clocks: 180 and 90 wave changes
    repeat (512) @(posedge clk);
    chk(nh - h0, 180);
    chk(nf - f0, 90);
    apb(1'b1, 12'h00C, 32'h0000_0002);
    cmd(4'h4, 8'h00);
    repeat (2) @(posedge clk);
    repeat (200) if (raster !== 1'b0 || motor !== 3'h0) @(posedge clk);
    cmd(4'h7, 8'h00);
    chk(survey, 1'b1);
    cmd(4'h4, 8'h00);
    repeat (2) @(posedge clk);
    chk(flip[1:0], 2'h1);
    repeat (700) if (irq !== 1'b1) @(posedge clk);
    chk(irq, 1'b1);
    chk({survey, gimbal}, 4'h7);
    rd(12'h008, 32'h0000_0003, 1'b0);
    print_verdict;
  end
endmodule
`default_nettype wire
